// *** rtl/irq_mask_defs.vh ***
// Register map and field constants for the interrupt mask bank
// Functional notes
// R1 - Mask bit 4 gates external clock event
// R2 - Mask bit 2 gates thermal warning event
// R3 - Mask bit 0 gates current result event
// R4 - Second mask bit 0 gates register reset
// R5 - Register reset gate reloads from OTP
// R6 - Converter mask bit 7 gates falling PG
// R7 - Mask bit 7 gates power good pin
// R8 - Interrupt asserted while unmasked flag set
`ifndef IRQ_MASK_DEFS_VH
`define IRQ_MASK_DEFS_VH

// ****************************************
// Register addresses
// ****************************************
`define ADDR_MASK_FIRST   8'h20
`define ADDR_MASK_SECOND  8'h21
`define ADDR_MASK_CONV    8'h22

// ****************************************
// Field positions
// ****************************************
`define BIT_CUR_RESULT    0
`define BIT_THERMAL       2
`define BIT_EXT_CLOCK     4
`define BIT_PG_PIN        7
`define BIT_REG_RESET     0
`define BIT_CONV_B_PGF    7

// ****************************************
// Writable bits and reset values
// ****************************************
`define WMASK_FIRST       8'hff
`define WMASK_SECOND      8'hff
`define WMASK_CONV        8'hdd
`define RST_FIRST         8'h00
`define RST_SECOND        8'h00
`define RST_CONV          8'h00

`endif

// *** rtl/pmic_interrupt_mask_bank.v ***
// Interrupt mask registers and masked interrupt output
`timescale 1ns/1ns
`include "irq_mask_defs.vh"

module pmic_interrupt_mask_bank
#(
   // Register and address widths of the serial register map
   parameter REG_W  = 8,
   parameter ADDR_W = 8,
   // Number of event sources combined into the interrupt
   parameter N_SRC  = 6
)
(
   // Clock and reset
   input  wire              mclk_i,
   input  wire              resetn_i,
   input  wire              clk_en_i,
   // Register access
   input  wire [ADDR_W-1:0] reg_addr_i,
   input  wire [REG_W-1:0]  reg_wdata_i,
   input  wire              reg_wr_i,
   output reg  [REG_W-1:0]  reg_rdata_o,
   // Reset-time OTP value for register reset gate
   input  wire              otp_reg_reset_gate_i,
   // Interrupt flags from event logic
   input  wire              ext_clock_flag_i,
   input  wire              thermal_warning_flag_i,
   input  wire              current_result_ready_flag_i,
   input  wire              power_good_pin_flag_i,
   input  wire              reg_reset_flag_i,
   input  wire              conv_b_pg_fall_flag_i,
   // Interrupt request, active low
   output reg               irq_n_o
);

   // ****************************************
   // Event source slots
   // ****************************************
   localparam SRC_EXT_CLOCK = 0;
   localparam SRC_THERMAL   = 1;
   localparam SRC_CUR       = 2;
   localparam SRC_PG_PIN    = 3;
   localparam SRC_REG_RESET = 4;
   localparam SRC_CONV_B    = 5;

   // ****************************************
   // Register select slots
   // ****************************************
   localparam SEL_FIRST     = 0;
   localparam SEL_SECOND    = 1;
   localparam SEL_CONV      = 2;

   // ****************************************
   // Address decode
   // ****************************************
   // Shared by the write and read paths so both see one map
   function [2:0] reg_select;
      input [ADDR_W-1:0] addr;
      begin
         case (addr)
            `ADDR_MASK_FIRST:
               reg_select = 3'b001;
            `ADDR_MASK_SECOND:
               reg_select = 3'b010;
            `ADDR_MASK_CONV:
               reg_select = 3'b100;
            default:
               reg_select = 3'b000;
         endcase
      end
   endfunction

   // ****************************************
   // Declarations
   // ****************************************
   reg  [REG_W-1:0] mask_first_r;
   reg  [REG_W-1:0] mask_first_nxt;
   reg  [REG_W-1:0] mask_second_r;
   reg  [REG_W-1:0] mask_second_nxt;
   reg  [REG_W-1:0] mask_conv_r;
   reg  [REG_W-1:0] mask_conv_nxt;
   reg              otp_load_r;
   reg  [REG_W-1:0] rdata_nxt;
   wire [2:0]       wr_sel;
   wire [2:0]       rd_sel;
   wire [N_SRC-1:0] flag_vec;
   wire [N_SRC-1:0] gate_vec;
   wire [N_SRC-1:0] unmasked_vec;
   wire             irq_nxt;

   // ****************************************
   // Access strobes
   // ****************************************
   assign wr_sel = reg_wr_i ? reg_select(reg_addr_i) : 3'b000;
   assign rd_sel = reg_select(reg_addr_i);

   // ****************************************
   // Mask next values
   // ****************************************
   always @*
   begin
      mask_first_nxt = mask_first_r;
      if (wr_sel[SEL_FIRST])
         mask_first_nxt = reg_wdata_i & `WMASK_FIRST;
   end

   always @*
   begin
      mask_second_nxt = mask_second_r;
      // Gate bit follows OTP only; a bus write there would be lost at reset
      if (otp_load_r)
         mask_second_nxt[`BIT_REG_RESET] = otp_reg_reset_gate_i; // R5
      else if (wr_sel[SEL_SECOND])
         mask_second_nxt[REG_W-1:1] = reg_wdata_i[REG_W-1:1]; // R5
   end

   always @*
   begin
      mask_conv_nxt = mask_conv_r;
      // Reserved bits are not stored and read back as zero
      if (wr_sel[SEL_CONV])
         mask_conv_nxt = reg_wdata_i & `WMASK_CONV;
   end

   // ****************************************
   // Mask registers
   // ****************************************
   always @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         mask_first_r  <= `RST_FIRST;
         mask_second_r <= `RST_SECOND;
         mask_conv_r   <= `RST_CONV;
         otp_load_r    <= 1'b1;
      end
      else if (clk_en_i)
      begin
         mask_first_r  <= mask_first_nxt;
         mask_second_r <= mask_second_nxt;
         mask_conv_r   <= mask_conv_nxt;
         // OTP value caught on first enabled edge after release
         otp_load_r    <= 1'b0;
      end
   end

   // ****************************************
   // Read back
   // ****************************************
   always @*
   begin
      rdata_nxt = {REG_W{1'b0}};
      if (rd_sel[SEL_FIRST])
         rdata_nxt = mask_first_r;
      if (rd_sel[SEL_SECOND])
         rdata_nxt = mask_second_r;
      if (rd_sel[SEL_CONV])
         rdata_nxt = mask_conv_r;
   end

   // Registered so the host sees a clean value one edge after the address
   always @(posedge mclk_i)
   begin
      if (!resetn_i)
         reg_rdata_o <= {REG_W{1'b0}};
      else if (clk_en_i)
         reg_rdata_o <= rdata_nxt;
   end

   // ****************************************
   // Event sources
   // ****************************************
   assign flag_vec[SRC_EXT_CLOCK] = ext_clock_flag_i;
   assign flag_vec[SRC_THERMAL]   = thermal_warning_flag_i;
   assign flag_vec[SRC_CUR]       = current_result_ready_flag_i;
   assign flag_vec[SRC_PG_PIN]    = power_good_pin_flag_i;
   assign flag_vec[SRC_REG_RESET] = reg_reset_flag_i;
   assign flag_vec[SRC_CONV_B]    = conv_b_pg_fall_flag_i;

   assign gate_vec[SRC_EXT_CLOCK] = mask_first_r[`BIT_EXT_CLOCK];   // R1
   assign gate_vec[SRC_THERMAL]   = mask_first_r[`BIT_THERMAL];     // R2
   assign gate_vec[SRC_CUR]       = mask_first_r[`BIT_CUR_RESULT];  // R3
   assign gate_vec[SRC_PG_PIN]    = mask_first_r[`BIT_PG_PIN];      // R7
   assign gate_vec[SRC_REG_RESET] = mask_second_r[`BIT_REG_RESET];  // R4
   assign gate_vec[SRC_CONV_B]    = mask_conv_r[`BIT_CONV_B_PGF];   // R6

   // ****************************************
   // Masked interrupt
   // ****************************************
   // Status bits live elsewhere and are never touched by masks
   genvar gi;
   generate
      for (gi = 0; gi < N_SRC; gi = gi + 1)
      begin : g_src
         // A set gate hides the event from the pin only
         assign unmasked_vec[gi] = flag_vec[gi] & ~gate_vec[gi];
      end
   endgenerate

   assign irq_nxt = |unmasked_vec; // R8

   // Registered output; flag clearing is up to the event logic
   always @(posedge mclk_i)
   begin
      if (!resetn_i)
         irq_n_o <= 1'b1;
      else if (clk_en_i)
         irq_n_o <= ~irq_nxt; // R8
   end

   // ****************************************
   // Limitations
   // ****************************************
   // Only the listed gates are kept here; the remaining converter and
   // regulator gates of the same registers are stored but not wired to
   // any event, so writing them changes read data only.

endmodule // pmic_interrupt_mask_bank

// *** tb/irq_chk_asserts.sv ***
// Checker for the interrupt mask bank
`timescale 1ns/1ns
module irq_chk(input wire logic mclk_i,resetn_i,clk_en_i,reg_wr_i,otp_reg_reset_gate_i,
   input wire logic [7:0] reg_addr_i,reg_wdata_i,reg_rdata_o,
   input wire logic ext_clock_flag_i,thermal_warning_flag_i,current_result_ready_flag_i,
   input wire logic power_good_pin_flag_i,reg_reset_flag_i,conv_b_pg_fall_flag_i,irq_n_o);
   logic [7:0] m1,m3;
   logic g,p;
   // Unmasked flags, one per event source
   wire [5:0] u={conv_b_pg_fall_flag_i,reg_reset_flag_i,power_good_pin_flag_i,
      current_result_ready_flag_i,thermal_warning_flag_i,ext_clock_flag_i}
      &~{m3[7],g,m1[7],m1[0],m1[2],m1[4]};
   always @(posedge mclk_i)
      if (!resetn_i) {m1,m3,g,p} <= 18'h1;
      else if (clk_en_i)
      begin
         p <= 1'b0;
         if (p) g <= otp_reg_reset_gate_i;
         if (reg_wr_i && reg_addr_i == 8'h20) m1 <= reg_wdata_i;
         if (reg_wr_i && reg_addr_i == 8'h22) m3 <= reg_wdata_i;
      end
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);
   AST_EXT: assert property (clk_en_i && u[0] |=> !irq_n_o) else $error("irq missed");
   AST_THERM: assert property (clk_en_i && u[1] |=> !irq_n_o) else $error("irq missed");
   AST_CUR: assert property (clk_en_i && u[2] |=> !irq_n_o) else $error("irq missed");
   AST_PGPIN: assert property (clk_en_i && u[3] |=> !irq_n_o) else $error("irq missed");
   AST_RRST: assert property (clk_en_i && u[4] |=> !irq_n_o) else $error("irq missed");
   AST_CONV: assert property (clk_en_i && u[5] |=> !irq_n_o) else $error("irq missed");
   AST_IDLE: assert property (clk_en_i && u == 0 |=> irq_n_o) else $error("irq spurious");
   AST_OTP: assert property (clk_en_i && reg_addr_i == 8'h21 |=> reg_rdata_o[0] == $past(g))
      else $error("gate bit wrong");
   AST_FREEZE: assert property (!clk_en_i |=> $stable(irq_n_o) && $stable(reg_rdata_o))
      else $error("outputs moved while clock enable low");
   cover property (clk_en_i && u[4]);
   cover property (reg_wr_i && reg_addr_i == 8'h21);
   cover property (clk_en_i && u[5]);
endmodule // irq_chk
bind pmic_interrupt_mask_bank irq_chk u_irq_chk(.*);

// *** tb/irq_host.sv ***
// Host model issuing register accesses
`timescale 1ns/1ns
module irq_host(input wire logic mclk_i, output logic [7:0] addr_o,wdata_o, output logic wr_o);
   initial {addr_o,wdata_o,wr_o} = 17'h0;
   task automatic xfer(input logic [7:0] a,d, input logic w);
      @(posedge mclk_i); #1 {addr_o,wdata_o,wr_o} = {a,d,w};
      @(posedge mclk_i); #1 wr_o = 1'b0;
   endtask
endmodule // irq_host

// *** tb/pmic_interrupt_mask_bank_tb.sv ***
// Bench for the interrupt mask bank
`timescale 1ns/1ns
module pmic_interrupt_mask_bank_tb;
   logic c=0,rn=0,o=1,en=1,w,q;
   logic [5:0] f=0;
   logic [7:0] a,d,r;
   int fails=0,comparisons=0;
   always #20 c = ~c;
   irq_host u_irq_host(.mclk_i(c),.addr_o(a),.wdata_o(d),.wr_o(w));
   pmic_interrupt_mask_bank u_pmic_interrupt_mask_bank(.mclk_i(c),.resetn_i(rn),.irq_n_o(q),
      .reg_addr_i(a),.reg_wdata_i(d),.reg_wr_i(w),.reg_rdata_o(r),.otp_reg_reset_gate_i(o),
      .ext_clock_flag_i(f[0]),.thermal_warning_flag_i(f[1]),.clk_en_i(en),
      .current_result_ready_flag_i(f[2]),.power_good_pin_flag_i(f[3]),
      .reg_reset_flag_i(f[4]),.conv_b_pg_fall_flag_i(f[5]));
   task chk(input logic [7:0] s,x);
      comparisons++;
      if (s !== x) begin fails++; $display("CHECK FAILED %0t %h %h",$time,s,x); end
   endtask
   task rst(input logic v);
      @(posedge c); #1 o = v; rn = 0; repeat (5) @(posedge c); #1 rn = 1;
   endtask
   // Each source: masked, then unmasked; the gate bit at 0x21 must ignore writes
   task t_mask;
      logic [7:0] ra[6]='{8'h20,8'h20,8'h20,8'h20,8'h21,8'h22};
      int bp[6]='{4,2,0,7,0,7};
      for (int i=0;i<6;i++)
      begin
         u_irq_host.xfer(ra[i],8'hff,1); f = 6'h1<<i; u_irq_host.xfer(ra[i],8'h00,0);
         chk(q,1); chk(r,ra[i]==8'h22 ? 8'hdd : 8'hff);
         u_irq_host.xfer(ra[i],~(8'h1<<bp[i]),1); u_irq_host.xfer(8'h30,8'hff,1);
         chk(q,i==4); chk(r,8'h00);
      end
   endtask
   task t_otp;
      rst(0); f = 6'h10; u_irq_host.xfer(8'h21,8'h00,0);
      chk(q,0); chk(r,8'h00);
      f = 6'h00; u_irq_host.xfer(8'h20,8'h00,1); chk(q,1);
   endtask
   // Clock enable low: the write must not land and outputs must hold
   task t_freeze;
      en = 0;
      f = 6'h01;
      u_irq_host.xfer(8'h20,8'hff,1);
      chk(q,1);
      chk(r,8'h00);
      en = 1;
      u_irq_host.xfer(8'h20,8'h00,0);
      chk(q,0);
      chk(r,8'h00);
   endtask
   task tally_and_finish;
      $display("comparisons %0d fails %0d",comparisons,fails);
      if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin #20000; fails++; tally_and_finish; end
   initial begin rst(1); t_mask; t_otp; t_freeze; tally_and_finish; end
endmodule // pmic_interrupt_mask_bank_tb
